// ==== src/carrier_switch_config.sv ====
// carrier switch configuration: address, scan bypass, gates, boot mode and processor straps
//
// Behaviour
// RULE1: logical address bits are switch OFF as one
// RULE2: bypass switch ON loops scan input to output
// RULE3: processor scan chain ignores all bypass switches
// RULE4: flash program and erase only while switch ON
// RULE5: watchdog switch off means watchdog never runs; an expiry right after a late switch-off still resets the processor
// RULE6: software disables watchdog through register 0x26
// RULE7: user switch readable, ON reads 0, OFF 1
// RULE8: firmware switch OFF at power-up selects update mode
// RULE9: address-size switch ON requests A32, else A24
// RULE10: shutdown switch ON turns off both card supplies
// RULE11: straps stay stable while processor held in reset
// RULE12: strap is one for switch OFF, drive strap inverted
// RULE13: two straps pick bus output hold delay
// RULE14: clock flip strap zero enables flipping
// RULE15: debug address strap zero enables debug output
// RULE16: serial strap one gives four bus clocks
// RULE17: extended addressing strap zero enables it
// RULE18: boot location strap one selects local bus
// RULE19: address map strap always driven to one
// RULE20: host mode strap one makes processor master
// RULE21: arbiter strap zero enables internal arbiter
// RULE22: watchdog active needs hardware and software permission
`timescale 1ns/10ps
`default_nettype none
`include "carrier_switch_config_defines.svh"

module carrier_switch_config #(
  parameter int NUM_MEZZ = 3,
  parameter int WDT_TIMEOUT_CYCLES = `WDT_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // switch bank, each bit high while its switch is ON
  input wire logic [7:0] addr_sw_on_i,
  input wire logic [NUM_MEZZ-1:0] scan_bypass_sw_on_i,
  input wire logic flash_we_sw_on_i,
  input wire logic wdt_sw_on_i,
  input wire logic user_sw_on_i,
  input wire logic fw_update_sw_on_i,
  input wire logic a32_sw_on_i,
  input wire logic card_shdn_sw_on_i,
  input wire logic [`NUM_STRAPS-1:0] strap_sw_on_i,
  // mezzanine scan chain at each connector
  input wire logic [NUM_MEZZ-1:0] mezz_scan_in_i,
  input wire logic [NUM_MEZZ-1:0] mezz_tdo_i,
  output logic [NUM_MEZZ-1:0] mezz_scan_out_o,
  // processor debug scan chain
  input wire logic cpu_tdo_i,
  output logic cpu_scan_out_o,
  // flash write strobe
  input wire logic cpu_flash_write_n_i,
  output logic flash_write_n_o,
  // card power control
  input wire logic card_vcc_req_i,
  input wire logic card_vpp_req_i,
  output logic card_vcc_en_o,
  output logic card_vpp_en_o,
  output logic card_power_shdn_o,
  // register port on the processor local bus
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // configuration results
  output logic [7:0] logical_address_o,
  output logic update_mode_o,
  output logic a32_space_o,
  output logic wdt_active_o,
  output logic wdt_reset_o,
  output logic proc_reset_n_o,
  // processor straps
  output logic hold_delay_strap_a_o,
  output logic hold_delay_strap_b_o,
  output logic mem_drive_strap_lo_o,
  output logic mem_drive_strap_hi_o,
  output logic periph_drive_strap_o,
  output logic clock_flip_strap_o,
  output logic debug_addr_strap_o,
  output logic serial_pin_select_strap_o,
  output logic ext_addressing_strap_o,
  output logic boot_location_strap_o,
  output logic address_map_strap_o,
  output logic host_mode_strap_o,
  output logic arbiter_disable_strap_o
);

  localparam int SYNC_W = 31 + 3 * NUM_MEZZ;
  localparam int TIMER_W = 8;
  localparam logic [TIMER_W-1:0] SETTLE_LAST = TIMER_W'(`SETTLE_CYCLES - 1);
  localparam logic [TIMER_W-1:0] HOLD_LAST = TIMER_W'(`STRAP_HOLD_CYCLES - 1);

  // synchronised pin levels
  logic [SYNC_W-1:0] sync_out;
  logic [7:0] addr_on;
  logic [NUM_MEZZ-1:0] bypass_on;
  logic flash_we_on;
  logic wdt_hw_on;
  logic user_on;
  logic fw_on;
  logic a32_on;
  logic shdn_on;
  logic [`NUM_STRAPS-1:0] strap_on;
  logic [NUM_MEZZ-1:0] scan_in_s;
  logic [NUM_MEZZ-1:0] tdo_s;
  logic cpu_tdo_s;
  logic flash_wr_n_s;
  logic vcc_req_s;
  logic vpp_req_s;

  // sequencing
  carrier_switch_config_pkg::boot_state_e state;
  carrier_switch_config_pkg::boot_state_e next_state;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic capture;

  // captured configuration
  logic [`NUM_STRAPS-1:0] strap_q;
  logic [`NUM_STRAPS-1:0] strap_new;

  // registers and watchdog
  logic [7:0] wdt_ctrl;
  logic [7:0] ops_status;
  logic [7:0] read_mux;
  logic wdt_ctrl_sel;
  logic ops_sel;
  logic wdt_kick;
  logic wdt_enable;
  logic wdt_expire;

  // every pin-level input passes the same synchroniser; the added latency on the
  // scan paths is a few fast-clock cycles, far below any usable scan clock period
  switch_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i({addr_sw_on_i, scan_bypass_sw_on_i, flash_we_sw_on_i, wdt_sw_on_i,
              user_sw_on_i, fw_update_sw_on_i, a32_sw_on_i, card_shdn_sw_on_i,
              strap_sw_on_i, mezz_scan_in_i, mezz_tdo_i, cpu_tdo_i,
              cpu_flash_write_n_i, card_vcc_req_i, card_vpp_req_i}),
    .sync_o(sync_out)
  );

  assign {addr_on, bypass_on, flash_we_on, wdt_hw_on, user_on, fw_on, a32_on, shdn_on,
          strap_on, scan_in_s, tdo_s, cpu_tdo_s, flash_wr_n_s, vcc_req_s,
          vpp_req_s} = sync_out;

  // power-up sequence: let the synchroniser settle, capture once, hold the
  // processor in reset with the straps steady, then release it
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state <= carrier_switch_config_pkg::ST_SETTLE;
      timer <= '0;
    end
    else
    begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  always_comb
  begin
    next_state = state;
    next_timer = timer + 1'b1;
    case (state)
      carrier_switch_config_pkg::ST_SETTLE:
      begin
        if (timer == SETTLE_LAST)
        begin
          next_state = carrier_switch_config_pkg::ST_CAPTURE;
          next_timer = '0;
        end
      end
      carrier_switch_config_pkg::ST_CAPTURE:
      begin
        next_state = carrier_switch_config_pkg::ST_HOLD;
        next_timer = '0;
      end
      carrier_switch_config_pkg::ST_HOLD:
      begin
        if (timer == HOLD_LAST)
        begin
          next_state = carrier_switch_config_pkg::ST_RUN;
          next_timer = '0;
        end
      end
      carrier_switch_config_pkg::ST_RUN:
      begin
        next_timer = '0;
        // an expired watchdog resets the processor; straps are not re-read
        if (wdt_expire)
          next_state = carrier_switch_config_pkg::ST_HOLD;
      end
      default:
      begin
        next_state = carrier_switch_config_pkg::ST_SETTLE;
        next_timer = '0;
      end
    endcase
  end

  assign capture = (state == carrier_switch_config_pkg::ST_CAPTURE);

  // straps: OFF gives one, the peripheral drive strap the reverse, address map fixed
  assign strap_new = (~strap_on ^ `STRAP_ON_IS_ONE) | `STRAP_FORCED_ONE; // [RULE12] [RULE19]

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      strap_q <= `STRAP_RESET;
      logical_address_o <= 8'h00;
      update_mode_o <= 1'b0;
      a32_space_o <= 1'b0;
      proc_reset_n_o <= 1'b0;
    end
    else
    begin
      // straps move only at capture, never while the processor samples them
      if (capture)
      begin
        strap_q <= strap_new; // [RULE11]
        logical_address_o <= ~addr_on; // [RULE1]
        update_mode_o <= ~fw_on; // [RULE8]
        a32_space_o <= a32_on; // [RULE9]
      end
      proc_reset_n_o <= (next_state == carrier_switch_config_pkg::ST_RUN);
    end
  end

  assign hold_delay_strap_a_o = strap_q[`STRAP_HOLD_A]; // [RULE13]
  assign hold_delay_strap_b_o = strap_q[`STRAP_HOLD_B]; // [RULE13]
  assign mem_drive_strap_lo_o = strap_q[`STRAP_MEM_LO];
  assign mem_drive_strap_hi_o = strap_q[`STRAP_MEM_HI];
  assign periph_drive_strap_o = strap_q[`STRAP_PERIPH];
  assign clock_flip_strap_o = strap_q[`STRAP_CLOCK_FLIP]; // [RULE14]
  assign debug_addr_strap_o = strap_q[`STRAP_DEBUG_ADDR]; // [RULE15]
  assign serial_pin_select_strap_o = strap_q[`STRAP_SERIAL_PIN]; // [RULE16]
  assign ext_addressing_strap_o = strap_q[`STRAP_EXT_ADDR]; // [RULE17]
  assign boot_location_strap_o = strap_q[`STRAP_BOOT_LOC]; // [RULE18]
  assign address_map_strap_o = strap_q[`STRAP_ADDR_MAP]; // [RULE19]
  assign host_mode_strap_o = strap_q[`STRAP_HOST_MODE]; // [RULE20]
  assign arbiter_disable_strap_o = strap_q[`STRAP_ARBITER]; // [RULE21]

  // scan, flash and card power paths
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mezz_scan_out_o <= '0;
      cpu_scan_out_o <= 1'b0;
      flash_write_n_o <= 1'b1;
      card_vcc_en_o <= 1'b0;
      card_vpp_en_o <= 1'b0;
      card_power_shdn_o <= 1'b0;
    end
    else
    begin
      mezz_scan_out_o <= (bypass_on & scan_in_s) | (~bypass_on & tdo_s); // [RULE2]
      cpu_scan_out_o <= cpu_tdo_s; // [RULE3]
      // a processor held in reset cannot write, so strobes seen then are noise
      flash_write_n_o <= flash_wr_n_s | ~flash_we_on | ~proc_reset_n_o; // [RULE4]
      card_vcc_en_o <= vcc_req_s & ~shdn_on; // [RULE10]
      card_vpp_en_o <= vpp_req_s & ~shdn_on; // [RULE10]
      card_power_shdn_o <= shdn_on; // [RULE10]
    end
  end

  // register port
  assign wdt_ctrl_sel = (reg_addr_i == `WDT_CTRL_OFFSET);
  assign ops_sel = (reg_addr_i == `OPS_STATUS_OFFSET);
  assign wdt_kick = reg_write_i & wdt_ctrl_sel & reg_wdata_i[`WDT_CTRL_KICK_BIT];
  assign wdt_enable = wdt_active_o & (state == carrier_switch_config_pkg::ST_RUN);

  always_comb
  begin
    ops_status = 8'h00;
    ops_status[`OPS_USER_SW_BIT] = ~user_on; // [RULE7]
    ops_status[`OPS_UPDATE_MODE_BIT] = update_mode_o;
    ops_status[`OPS_A32_BIT] = a32_space_o;
    ops_status[`OPS_FLASH_WE_BIT] = flash_we_on;
    ops_status[`OPS_WDT_HW_EN_BIT] = wdt_hw_on;
    ops_status[`OPS_WDT_ACTIVE_BIT] = wdt_active_o;
  end

  assign read_mux = wdt_ctrl_sel ? wdt_ctrl : (ops_sel ? ops_status : `REG_UNMAPPED_DATA);

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wdt_ctrl <= `WDT_CTRL_RESET;
      reg_rdata_o <= 8'h00;
      wdt_active_o <= 1'b0;
    end
    else
    begin
      // the kick bit is an action and always reads back zero
      if (reg_write_i && wdt_ctrl_sel)
        wdt_ctrl <= reg_wdata_i & ~(8'h01 << `WDT_CTRL_KICK_BIT); // [RULE6]
      if (reg_read_i)
        reg_rdata_o <= read_mux;
      wdt_active_o <= wdt_hw_on & ~wdt_ctrl[`WDT_CTRL_DISABLE_BIT]; // [RULE5] [RULE22]
    end
  end

  watchdog_counter #(
    .TIMEOUT_CYCLES(WDT_TIMEOUT_CYCLES)
  ) u_wdt (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .enable_i(wdt_enable),
    .kick_i(wdt_kick),
    .expire_o(wdt_expire)
  );

  // hardware gate checked again at wdt_reset_o only; after a late switch change the ungated expiry still resets the processor
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      wdt_reset_o <= 1'b0;
    else
      wdt_reset_o <= wdt_expire & wdt_hw_on; // [RULE5]
  end

  // checks
  localparam int HOLD_BOUND = `STRAP_HOLD_CYCLES + 2;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_addr_capture;
    capture |=> logical_address_o == ~$past(addr_on);
  endproperty
  a_addr_capture: assert property (p_addr_capture) else $error("address not captured"); // [RULE1]

  property p_bypass;
    ##1 mezz_scan_out_o == $past((bypass_on & scan_in_s) | (~bypass_on & tdo_s));
  endproperty
  a_bypass: assert property (p_bypass) else $error("scan bypass path wrong"); // [RULE2]

  property p_cpu_scan;
    $changed(bypass_on) && $stable(cpu_tdo_s) |=> $stable(cpu_scan_out_o);
  endproperty
  a_cpu_scan: assert property (p_cpu_scan) else $error("cpu chain moved by bypass"); // [RULE3]

  property p_flash_block;
    !flash_we_on |=> flash_write_n_o;
  endproperty
  a_flash_block: assert property (p_flash_block) else $error("flash write leaked"); // [RULE4]

  property p_wdt_hw_gate;
    !wdt_hw_on [*2] |-> !wdt_reset_o && !wdt_active_o;
  endproperty
  a_wdt_hw_gate: assert property (p_wdt_hw_gate) else $error("watchdog ran while gated"); // [RULE5]

  property p_wdt_sw_off;
    reg_write_i && wdt_ctrl_sel && reg_wdata_i[`WDT_CTRL_DISABLE_BIT] |=> ##1 !wdt_active_o;
  endproperty
  a_wdt_sw_off: assert property (p_wdt_sw_off) else $error("software disable ignored"); // [RULE6]

  property p_wdt_active;
    ##1 wdt_active_o == ($past(wdt_hw_on) && !$past(wdt_ctrl[`WDT_CTRL_DISABLE_BIT]));
  endproperty
  a_wdt_active: assert property (p_wdt_active) else $error("watchdog activity wrong"); // [RULE22]

  property p_user_sw;
    reg_read_i && ops_sel |=> reg_rdata_o[`OPS_USER_SW_BIT] == !$past(user_on);
  endproperty
  a_user_sw: assert property (p_user_sw) else $error("user switch bit wrong"); // [RULE7]

  property p_boot_mode;
    capture |=> update_mode_o == !$past(fw_on) && a32_space_o == $past(a32_on);
  endproperty
  a_boot_mode: assert property (p_boot_mode) else $error("boot or space mode wrong"); // [RULE8]

  property p_card_off;
    shdn_on |=> card_power_shdn_o && !card_vcc_en_o && !card_vpp_en_o;
  endproperty
  a_card_off: assert property (p_card_off) else $error("card power not shut down"); // [RULE10]

  property p_strap_stable;
    !capture |=> $stable(strap_q);
  endproperty
  a_strap_stable: assert property (p_strap_stable) else $error("strap moved in reset"); // [RULE11]

  property p_strap_value;
    capture |=> strap_q == ((~$past(strap_on) ^ `STRAP_ON_IS_ONE) | `STRAP_FORCED_ONE);
  endproperty
  a_strap_value: assert property (p_strap_value) else $error("strap polarity wrong"); // [RULE12]

  property p_release;
    capture |=> !proc_reset_n_o [*8] ##[1:HOLD_BOUND] proc_reset_n_o;
  endproperty
  a_release: assert property (p_release) else $error("processor reset not released"); // [RULE11]

  property p_map_one;
    address_map_strap_o;
  endproperty
  a_map_one: assert property (p_map_one) else $error("address map strap low"); // [RULE19]

  c_capture: cover property (capture ##1 state == carrier_switch_config_pkg::ST_HOLD);
  c_wdt_reset: cover property (wdt_reset_o ##1 !proc_reset_n_o);
  c_bypass: cover property (bypass_on[0] && scan_in_s[0] != tdo_s[0]);
  c_flash_write: cover property (flash_we_on && !flash_write_n_o);

endmodule : carrier_switch_config

`default_nettype wire

// ==== src/carrier_switch_config_defines.svh ====
// offsets, field positions, reset values and timing counts of the switch configuration logic
`ifndef CARRIER_SWITCH_CONFIG_DEFINES_SVH
`define CARRIER_SWITCH_CONFIG_DEFINES_SVH

// register offsets, control reset value and unmapped read data of the processor local bus register port
`define WDT_CTRL_OFFSET 8'h26
`define OPS_STATUS_OFFSET 8'h24
`define WDT_CTRL_RESET 8'h00
`define REG_UNMAPPED_DATA 8'h00

// watchdog timer control fields
`define WDT_CTRL_DISABLE_BIT 0
`define WDT_CTRL_KICK_BIT 1

// operations status fields
`define OPS_USER_SW_BIT 0
`define OPS_UPDATE_MODE_BIT 1
`define OPS_A32_BIT 2
`define OPS_FLASH_WE_BIT 3
`define OPS_WDT_HW_EN_BIT 4
`define OPS_WDT_ACTIVE_BIT 5

// strap vector positions
`define NUM_STRAPS 13
`define STRAP_HOLD_A 0
`define STRAP_HOLD_B 1
`define STRAP_MEM_LO 2
`define STRAP_MEM_HI 3
`define STRAP_PERIPH 4
`define STRAP_CLOCK_FLIP 5
`define STRAP_DEBUG_ADDR 6
`define STRAP_SERIAL_PIN 7
`define STRAP_EXT_ADDR 8
`define STRAP_BOOT_LOC 9
`define STRAP_ADDR_MAP 10
`define STRAP_HOST_MODE 11
`define STRAP_ARBITER 12

// recommended strap levels, driven until the switches are captured
`define STRAP_RESET 13'h0EEE
// straps where switch ON gives a one
`define STRAP_ON_IS_ONE 13'h0010
// straps forced to one whatever the switch says
`define STRAP_FORCED_ONE 13'h0400

// timing
`define CLOCK_PERIOD_NS 10
`define SETTLE_NS 100
`define SETTLE_CYCLES ((`SETTLE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define STRAP_HOLD_NS 1000
`define STRAP_HOLD_CYCLES ((`STRAP_HOLD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define WDT_TIMEOUT_MS 100
`define WDT_TIMEOUT_CYCLES (`WDT_TIMEOUT_MS * 1000000 / `CLOCK_PERIOD_NS)

`endif

// ==== src/carrier_switch_config_pkg.sv ====
// types of the switch configuration logic
package carrier_switch_config_pkg;

  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_CAPTURE,
    ST_HOLD,
    ST_RUN
  } boot_state_e;

endpackage : carrier_switch_config_pkg

// ==== src/switch_sync.sv ====
// three-stage synchroniser whose output moves once the last two stages agree
`timescale 1ns/10ps
`default_nettype none

module switch_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // asynchronous inputs and their settled copies
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic [2:0] stage;
      logic held;
      always_ff @(posedge clock_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          stage <= 3'h0;
          held <= 1'b0;
        end
        else
        begin
          stage <= {stage[1:0], async_i[g]};
          if (stage[1] == stage[2])
            held <= stage[2];
        end
      end
      assign sync_o[g] = held;
    end
  endgenerate

endmodule : switch_sync

`default_nettype wire

// ==== src/watchdog_counter.sv ====
// watchdog timer: counts while enabled, restarts on a kick, pulses on expiry
`timescale 1ns/10ps
`default_nettype none

module watchdog_counter #(
  parameter int TIMEOUT_CYCLES = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // control
  input wire logic enable_i,
  input wire logic kick_i,
  // expiry pulse
  output logic expire_o
);

  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYCLES - 1);

  logic [CW-1:0] count;

  // a disabled watchdog holds its count at zero, so it can never expire
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      count <= '0;
      expire_o <= 1'b0;
    end
    else
    begin
      expire_o <= 1'b0;
      if (!enable_i || kick_i)
        count <= '0;
      else if (count == LAST)
      begin
        count <= '0;
        expire_o <= 1'b1;
      end
      else
        count <= count + 1'b1;
    end
  end

endmodule : watchdog_counter

`default_nettype wire

// ==== sim/strap_latch_model.sv ====
// processor model: latches its configuration straps when its reset is released
`timescale 1ns/10ps
`default_nettype none

module strap_latch_model (
  // straps and reset as seen at the processor pins
  input wire logic [12:0] strap_i,
  input wire logic proc_reset_n_i,
  // configuration the processor runs with
  output logic [12:0] config_o
);
  initial
  begin
    config_o = 13'h0000;
  end

  // only the level present as reset lets go counts, later moves are ignored
  always @(posedge proc_reset_n_i)
  begin
    config_o <= strap_i;
  end
endmodule : strap_latch_model
`default_nettype wire

// ==== sim/carrier_switch_config_tb_top.sv ====
// self-checking bench for the carrier switch configuration logic
`timescale 1ns/10ps
`default_nettype none
`include "carrier_switch_config_defines.svh"

module carrier_switch_config_tb_top;
  logic clock_i, reset_n_i, b;
  logic [7:0] addr_sw, reg_addr, reg_wdata, reg_rdata, logical_address, d;
  logic [2:0] bypass_sw, scan_in, tdo, scan_out;
  logic flash_we_sw, wdt_sw, user_sw, fw_sw, a32_sw, shdn_sw;
  logic [12:0] strap_sw, straps, latched;
  logic cpu_tdo, cpu_scan_out, cpu_wr_n, flash_wr_n, vcc_req, vpp_req, vcc_en, vpp_en, shdn;
  logic reg_write, reg_read, update_mode, a32_space, wdt_active, wdt_reset, proc_reset_n;
  int n_errors, tests_run, n_wdt, snap, i;

  carrier_switch_config #(.NUM_MEZZ(3), .WDT_TIMEOUT_CYCLES(50)) dut_u (
    .clock_i(clock_i), .reset_n_i(reset_n_i),
    .addr_sw_on_i(addr_sw), .scan_bypass_sw_on_i(bypass_sw),
    .flash_we_sw_on_i(flash_we_sw), .wdt_sw_on_i(wdt_sw), .user_sw_on_i(user_sw),
    .fw_update_sw_on_i(fw_sw), .a32_sw_on_i(a32_sw), .card_shdn_sw_on_i(shdn_sw),
    .strap_sw_on_i(strap_sw), .mezz_scan_in_i(scan_in), .mezz_tdo_i(tdo),
    .mezz_scan_out_o(scan_out), .cpu_tdo_i(cpu_tdo), .cpu_scan_out_o(cpu_scan_out),
    .cpu_flash_write_n_i(cpu_wr_n), .flash_write_n_o(flash_wr_n),
    .card_vcc_req_i(vcc_req), .card_vpp_req_i(vpp_req), .card_vcc_en_o(vcc_en),
    .card_vpp_en_o(vpp_en), .card_power_shdn_o(shdn),
    .reg_addr_i(reg_addr), .reg_write_i(reg_write), .reg_read_i(reg_read),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .logical_address_o(logical_address), .update_mode_o(update_mode),
    .a32_space_o(a32_space), .wdt_active_o(wdt_active), .wdt_reset_o(wdt_reset),
    .proc_reset_n_o(proc_reset_n),
    .hold_delay_strap_a_o(straps[0]), .hold_delay_strap_b_o(straps[1]),
    .mem_drive_strap_lo_o(straps[2]), .mem_drive_strap_hi_o(straps[3]),
    .periph_drive_strap_o(straps[4]), .clock_flip_strap_o(straps[5]),
    .debug_addr_strap_o(straps[6]), .serial_pin_select_strap_o(straps[7]),
    .ext_addressing_strap_o(straps[8]), .boot_location_strap_o(straps[9]),
    .address_map_strap_o(straps[10]), .host_mode_strap_o(straps[11]),
    .arbiter_disable_strap_o(straps[12])
  );

  strap_latch_model cpu_u (
    .strap_i(straps),
    .proc_reset_n_i(proc_reset_n),
    .config_o(latched)
  );

  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
  begin
    if (wdt_reset === 1'b1)
      n_wdt++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results;
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    cyc(1);
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    cyc(1);
    reg_write = 1'b0;
  endtask : wr

  // rdata holds until the next read, so one spare cycle costs nothing
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    cyc(1);
    reg_addr = a;
    reg_read = 1'b1;
    cyc(1);
    reg_read = 1'b0;
    cyc(1);
    v = reg_rdata;
  endtask : rd

  task automatic boot(input logic [12:0] s, input logic [7:0] a, input logic fw, input logic w);
    int k;
    strap_sw = s;
    addr_sw = a;
    fw_sw = fw;
    a32_sw = w;
    reset_n_i = 1'b0;
    cyc(16);
    reset_n_i = 1'b1;
    k = 0;
    while (proc_reset_n !== 1'b1 && k < 400)
    begin
      cyc(1);
      k++;
    end
    if (k >= 400)
    begin
      n_errors++;
      results();
    end
    // braces keep each inversion at its own width inside the wider argument
    chk(straps, {(~s ^ 13'h0010) | 13'h0400});
    chk(straps[1:0], {~s[1:0]});
    chk(straps[5], {~s[5]});
    chk(straps[6], {~s[6]});
    chk(straps[7], {~s[7]});
    chk(straps[8], {~s[8]});
    chk(straps[9], {~s[9]});
    chk(straps[10], 1'b1);
    chk(straps[11], {~s[11]});
    chk(straps[12], {~s[12]});
    chk(latched, {(~s ^ 13'h0010) | 13'h0400});
    chk(logical_address, {~a});
    chk(update_mode, {~fw});
    chk(a32_space, w);
    // switches moved after capture must not reach the processor
    strap_sw = ~s;
    addr_sw = ~a;
    cyc(10);
    chk(straps, {(~s ^ 13'h0010) | 13'h0400});
    chk(logical_address, {~a});
  endtask : boot

  initial
  begin
    n_errors = 0;
    tests_run = 0;
    n_wdt = 0;
    bypass_sw = 3'b000;
    scan_in = 3'b000;
    tdo = 3'b111;
    cpu_tdo = 1'b0;
    flash_we_sw = 1'b0;
    wdt_sw = 1'b0;
    user_sw = 1'b0;
    shdn_sw = 1'b0;
    cpu_wr_n = 1'b1;
    vcc_req = 1'b0;
    vpp_req = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    // address 36 with the firmware update switch OFF, then two other patterns
    boot(13'h0000, 8'hDB, 1'b0, 1'b1);
    boot(13'h1FFF, 8'h00, 1'b1, 1'b0);
    boot(13'h0A5A, 8'hFF, 1'b1, 1'b1);
    for (i = 0; i < 2; i++)
    begin
      b = i[0];
      cpu_tdo = ~b;
      // bypass moves on its own so the processor chain sees a pure bypass change
      cyc(4);
      bypass_sw = b ? 3'b101 : 3'b010;
      scan_in = 3'b011 ^ {3{b}};
      tdo = ~scan_in;
      cyc(8);
      chk(scan_out, (scan_in & bypass_sw) | (tdo & ~bypass_sw));
      chk(cpu_scan_out, {~b});
      flash_we_sw = b;
      cpu_wr_n = 1'b0;
      shdn_sw = ~b;
      vcc_req = 1'b1;
      vpp_req = 1'b1;
      user_sw = b;
      cyc(8);
      chk(flash_wr_n, {~b});
      chk({shdn, vcc_en, vpp_en}, {~b, b, b});
      rd(`OPS_STATUS_OFFSET, d);
      chk(d[0], {~b});
    end
    cpu_wr_n = 1'b1;
    wr(8'h31, 8'hFF);
    rd(8'h31, d);
    chk(d, 8'h00);
    chk(wdt_active, 1'b0);
    chk(n_wdt[15:0], 16'h0000);
    wr(`WDT_CTRL_OFFSET, 8'h01);
    wdt_sw = 1'b1;
    cyc(100);
    chk({wdt_active, n_wdt[14:0]}, 16'h0000);
    rd(`WDT_CTRL_OFFSET, d);
    chk(d, 8'h01);
    wr(`WDT_CTRL_OFFSET, 8'h00);
    cyc(6);
    chk(wdt_active, 1'b1);
    // kicks spaced well inside the timeout keep the watchdog from expiring
    snap = n_wdt;
    repeat (3)
    begin
      cyc(30);
      wr(`WDT_CTRL_OFFSET, 8'h02);
    end
    chk(n_wdt[15:0], snap[15:0]);
    rd(`WDT_CTRL_OFFSET, d);
    chk(d, 8'h00);
    cyc(80);
    chk(n_wdt != 0, 1'b1);
    wdt_sw = 1'b0;
    cyc(130);
    snap = n_wdt;
    cyc(200);
    chk(n_wdt[15:0], snap[15:0]);
    chk(wdt_active, 1'b0);
    results();
  end
endmodule : carrier_switch_config_tb_top
`default_nettype wire
